// ==== rtl/mcg_pkg.sv ====
// Shared constants and types of the machine clock generator
package mcg_pkg;

	// ==========================================================
	// Timing
	localparam int REF_CLK_MHZ   = 200;
	localparam int LOCK_TIME_US  = 30;
	localparam int LOCK_CYCLES   = LOCK_TIME_US * REF_CLK_MHZ;
	localparam int LOCK_W        = 16;

	// ==========================================================
	// Register bus
	localparam int AXI_AW = 4;
	localparam int AXI_DW = 32;
	localparam logic [AXI_AW-1:0] OFS_MODE = 4'h0;
	localparam logic [AXI_AW-1:0] OFS_BANK = 4'h4;
	localparam logic [AXI_AW-1:0] OFS_STAT = 4'h8;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Clock mode register fields
	localparam int MODE_FRAC_LSB = 0;
	localparam int MODE_INT_LSB  = 2;
	localparam int MODE_PLL_BIT  = 8;
	localparam int MODE_DIV4_BIT = 9;
	localparam logic [3:0] MULT_INT_RESET  = 4'h1;
	localparam logic [1:0] MULT_FRAC_RESET = 2'h0;

	// ==========================================================
	// Bank switch control register: machine_clock_output divide field
	localparam int DIV_LSB = 0;
	localparam logic [1:0] DIV_NONE  = 2'h0;
	localparam logic [1:0] DIV_BY2   = 2'h1;
	localparam logic [1:0] DIV_BY4   = 2'h2;
	localparam logic [1:0] DIV_RESET = DIV_BY4;

	// ==========================================================
	// Status register fields
	localparam int STAT_LOCK_BIT = 0;
	localparam int STAT_OSC_BIT  = 1;
	localparam int STAT_PLL_BIT  = 2;
	localparam int STAT_DIV4_BIT = 3;
	localparam int STAT_PINS_LSB = 4;

	// ==========================================================
	// Mode pin codes, ordered {pin_1, pin_2, pin_3}
	localparam logic [2:0] PINS_DIV2_NO_OSC = 3'h0;
	localparam logic [2:0] PINS_DIV4        = 3'h5;
	localparam logic [2:0] PINS_DIV2        = 3'h7;

	// ==========================================================
	// Clock source of the machine clock
	typedef enum logic [1:0] {
		SRC_DIV2 = 2'b00,
		SRC_DIV4 = 2'b01,
		SRC_PLL  = 2'b10
	} mcg_src_t;

endpackage : mcg_pkg

// ==== rtl/mcg_ref_meter.sv ====
// Reference clock edge detector and period meter
`timescale 1ns/10ps
module mcg_ref_meter #(
	parameter int PER_W = 16
) (
	input  wire logic             ref_clk,
	input  wire logic             reset,
	input  wire logic             ref_level,
	output logic                  ref_rise,
	output logic [PER_W-1:0]      period,
	output logic                  period_valid
);
	import mcg_pkg::*;

	typedef struct packed {
		logic             prev;
		logic             armed;
		logic             rise;
		logic [PER_W-1:0] cnt;
		logic [PER_W-1:0] per;
		logic             valid;
	} mcg_meter_st_t;

	mcg_meter_st_t q, d;

	always_comb begin
		d = q;
		d.prev = ref_level;
		d.rise = ref_level & ~q.prev;
		if (ref_level && !q.prev) begin
			d.per   = q.cnt + PER_W'(1);
			d.cnt   = '0;
			// First rise after reset only starts the count: partial period
			d.armed = 1'b1;
			d.valid = q.armed & ~&q.cnt;
		end else if (!(&q.cnt)) begin
			d.cnt = q.cnt + PER_W'(1);
		end else begin
			// Stopped reference: no rate to follow, hold count and period, drop valid
			d.valid = 1'b0;
		end
		if (reset) begin
			d = '0;
			// Start from the pin's level so reset gives no false edge
			d.prev = ref_level;
		end
	end

	always_ff @(posedge ref_clk) begin
		q <= d;
	end

	assign ref_rise     = q.rise;
	assign period       = q.per;
	assign period_valid = q.valid;

endmodule : mcg_ref_meter

// ==== rtl/mcg_out_div.sv ====
// Clock output divider driven by machine clock half-period events
`timescale 1ns/10ps
module mcg_out_div (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        mach_toggle,
	input  wire logic [1:0]  divide_field,
	output logic             clock_out
);
	import mcg_pkg::*;

	typedef struct packed {
		logic [1:0] cnt;
		logic       out;
	} mcg_div_st_t;

	mcg_div_st_t q, d;
	logic [1:0]  lim;

	always_comb begin
		d = q;
		case (divide_field)
			DIV_NONE: lim = 2'h0;
			DIV_BY2:  lim = 2'h1;
			default:  lim = 2'h3;
		endcase
		if (mach_toggle) begin
			if (q.cnt >= lim) begin
				d.out = ~q.out;
				d.cnt = 2'h0;
			end else begin
				d.cnt = q.cnt + 2'h1;
			end
		end
		if (reset) begin
			d = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		q <= d;
	end

	assign clock_out = q.out;

endmodule : mcg_out_div

// ==== rtl/mcg_clock_gen.sv ====
// Machine clock generator top: mode decode, multiplier, lock timer, register slave
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps

// Operation
// - Machine clock: reference divided or multiplied
// - Oscillator enabled only by oscillator pin codes
// - Output is multiple set by mode register
// - Pin codes 000, 101, 111 select bypass
// - Output divide resets to four, 00 undivided
// - Software programs multiplier after reset
// - Integer, quarter, half and three-quarter factors
// - Lock reached within 30 us of change
// - Bypass modes static at any reference rate
// - Prefer multiplier for highest machine rate
module mcg_clock_gen #(
	parameter logic [mcg_pkg::LOCK_W-1:0] LOCK_CYCLES = mcg_pkg::LOCK_W'(mcg_pkg::LOCK_CYCLES),
	parameter int                         PER_W       = 16
) (
	input  wire logic                        ref_clk,
	input  wire logic                        reset,
	input  wire logic                        reference_clock_input,
	input  wire logic                        mode_select_pin_1,
	input  wire logic                        mode_select_pin_2,
	input  wire logic                        mode_select_pin_3,
	input  wire logic [mcg_pkg::AXI_AW-1:0]  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [mcg_pkg::AXI_DW-1:0]  s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [mcg_pkg::AXI_AW-1:0]  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [mcg_pkg::AXI_DW-1:0]       s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	output logic                             osc_enable,
	output logic                             crystal_drive_pin,
	output logic                             pll_enable,
	output logic                             pll_locked,
	output logic                             machine_clock,
	output logic                             machine_clock_output
);
	import mcg_pkg::*;

	localparam int ACC_W = PER_W + 3;

	typedef struct packed {
		logic              awhave;
		logic [AXI_AW-1:0] awaddr;
		logic              whave;
		logic [AXI_DW-1:0] wdata;
		logic [3:0]        wstrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [AXI_DW-1:0] rdata;
		logic [1:0]        rresp;
		mcg_src_t          src;
		logic              osc_en;
		logic              xdrv;
		logic [3:0]        mint;
		logic [1:0]        mfrac;
		logic [1:0]        divf;
		logic [2:0]        pins;
		logic [LOCK_W-1:0] lock_cnt;
		logic              locked;
		logic [ACC_W-1:0]  acc;
		logic              div4_ph;
		logic              mclk;
	} mcg_top_st_t;

	mcg_top_st_t      q, d;
	logic             ref_rise;
	logic [PER_W-1:0] ref_period;
	logic             period_valid;
	logic             mach_tgl;
	logic [2:0]       pins_now;
	logic [5:0]       mult_q4;
	logic [ACC_W-1:0] acc_sum;
	logic [ACC_W-1:0] acc_lim;

	// Ordered as the package pin codes
	assign pins_now = {mode_select_pin_1, mode_select_pin_2, mode_select_pin_3};

	// ==========================================================
	// Reference edge and period
	mcg_ref_meter #(
		.PER_W (PER_W)
	) u_meter (
		.ref_clk      (ref_clk),
		.reset        (reset),
		.ref_level    (reference_clock_input),
		.ref_rise     (ref_rise),
		.period       (ref_period),
		.period_valid (period_valid)
	);

	// ==========================================================
	// Register read view
	function automatic logic [AXI_DW-1:0] read_word(input mcg_top_st_t s,
			input logic [AXI_AW-1:0] a);
		logic [AXI_DW-1:0] w;
		w = '0;
		case (a)
			OFS_MODE: begin
				w[MODE_FRAC_LSB +: 2] = s.mfrac;
				w[MODE_INT_LSB +: 4]  = s.mint;
				w[MODE_PLL_BIT]       = (s.src == SRC_PLL);
				w[MODE_DIV4_BIT]      = (s.src == SRC_DIV4);
			end
			OFS_BANK: w[DIV_LSB +: 2] = s.divf;
			OFS_STAT: begin
				w[STAT_LOCK_BIT]      = s.locked;
				w[STAT_OSC_BIT]       = s.osc_en;
				w[STAT_PLL_BIT]       = (s.src == SRC_PLL);
				w[STAT_DIV4_BIT]      = (s.src == SRC_DIV4);
				w[STAT_PINS_LSB +: 3] = s.pins;
			end
			default: w = '0;
		endcase
		return w;
	endfunction : read_word

	// ==========================================================
	// Next state
	always_comb begin
		d        = q;
		mach_tgl = 1'b0;
		// Zero integer part would stop the clock; run it with an integer part of one
		mult_q4  = {(q.mint == 4'h0) ? 4'h1 : q.mint, q.mfrac};
		acc_sum  = q.acc + ACC_W'({mult_q4, 1'b0});
		// Four times the period, matching the two fraction bits of the factor
		acc_lim  = {1'b0, ref_period, 2'b00};

		// ------------------------------------------------------
		// Settling timer counts first, so a mode write below reloads it
		if (q.lock_cnt != '0) begin
			d.lock_cnt = q.lock_cnt - LOCK_W'(1);
		end

		// ------------------------------------------------------
		// Register bus
		// Write address and data are taken independently, in either order
		if (s_axi_awvalid && !q.awhave && !q.bvalid) begin
			d.awhave = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !q.whave && !q.bvalid) begin
			d.whave = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		if (q.awhave && q.whave) begin
			d.awhave = 1'b0;
			d.whave  = 1'b0;
			d.bvalid = 1'b1;
			d.bresp  = RESP_OKAY;
			case (q.awaddr)
				OFS_MODE: begin
					if (q.wstrb[0]) begin
						d.mfrac = q.wdata[MODE_FRAC_LSB +: 2];
						d.mint  = q.wdata[MODE_INT_LSB +: 4];
					end
					if (q.wstrb[1]) begin
						if (q.wdata[MODE_PLL_BIT]) begin
							d.src = SRC_PLL;
						end else if (q.wdata[MODE_DIV4_BIT]) begin
							d.src = SRC_DIV4;
						end else begin
							d.src = SRC_DIV2;
						end
					end
					// A mode write with either low byte strobe set restarts the settling window
					if (|q.wstrb[1:0]) begin
						d.lock_cnt = LOCK_CYCLES;
					end
				end
				OFS_BANK: begin
					if (q.wstrb[0]) begin
						d.divf = q.wdata[DIV_LSB +: 2];
					end
				end
				OFS_STAT: d.bresp = RESP_OKAY;
				default:  d.bresp = RESP_SLVERR;
			endcase
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end

		if (q.rvalid) begin
			if (s_axi_rready) begin
				d.rvalid = 1'b0;
			end
		end else if (s_axi_arvalid) begin
			d.rvalid = 1'b1;
			d.rdata  = read_word(q, s_axi_araddr);
			case (s_axi_araddr)
				OFS_MODE, OFS_BANK, OFS_STAT: d.rresp = RESP_OKAY;
				default:                      d.rresp = RESP_SLVERR;
			endcase
		end

		// ------------------------------------------------------
		// Machine clock half-period events
		case (q.src)
			SRC_DIV2: begin
				// Purely edge driven: holds indefinitely if the reference stops
				mach_tgl = ref_rise;
			end
			SRC_DIV4: begin
				// Toggle on every second reference rise
				if (ref_rise) begin
					d.div4_ph = ~q.div4_ph;
					mach_tgl  = q.div4_ph;
				end
			end
			SRC_PLL: begin
				// Two events per reference period per unit of factor.
				// Limited to one event per cycle, so output tops out at half
				// of ref_clk; bypass modes top out lower, at one event per two cycles in SRC_DIV2 and one per four in SRC_DIV4.
				if (period_valid) begin
					if (acc_sum >= acc_lim) begin
						d.acc    = acc_sum - acc_lim;
						mach_tgl = 1'b1;
					end else begin
						d.acc = acc_sum;
					end
				end
			end
			default: mach_tgl = 1'b0;
		endcase
		if (mach_tgl) begin
			d.mclk = ~q.mclk;
		end

		// ------------------------------------------------------
		// Lock follows the source written this cycle: bypass is locked at once
		d.locked = (d.src != SRC_PLL) || (d.lock_cnt == '0);
		d.xdrv   = q.osc_en & ~reference_clock_input;

		// ------------------------------------------------------
		// Synchronous reset catches the mode pins
		if (reset) begin
			d          = '0;
			d.pins     = pins_now;
			d.mint     = MULT_INT_RESET;
			d.mfrac    = MULT_FRAC_RESET;
			d.divf     = DIV_RESET;
			d.osc_en   = (pins_now != PINS_DIV2_NO_OSC);
			d.lock_cnt = LOCK_CYCLES;
			case (pins_now)
				PINS_DIV2_NO_OSC: d.src = SRC_DIV2;
				PINS_DIV4:        d.src = SRC_DIV4;
				PINS_DIV2:        d.src = SRC_DIV2;
				default:          d.src = SRC_PLL;
			endcase
			// Bypass codes report locked straight out of reset
			d.locked   = (d.src != SRC_PLL);
		end
	end

	always_ff @(posedge ref_clk) begin
		q <= d;
	end

	// ==========================================================
	// Clock output divider
	mcg_out_div u_div (
		.ref_clk      (ref_clk),
		.reset        (reset),
		.mach_toggle  (mach_tgl),
		.divide_field (q.divf),
		.clock_out    (machine_clock_output)
	);

	// ==========================================================
	// Outputs
	// Readies come from held state only, no path from the valids
	assign s_axi_awready     = ~q.awhave & ~q.bvalid;
	assign s_axi_wready      = ~q.whave & ~q.bvalid;
	assign s_axi_bvalid      = q.bvalid;
	assign s_axi_bresp       = q.bresp;
	assign s_axi_arready     = ~q.rvalid;
	assign s_axi_rvalid      = q.rvalid;
	assign s_axi_rdata       = q.rdata;
	assign s_axi_rresp       = q.rresp;
	assign osc_enable        = q.osc_en;
	assign crystal_drive_pin = q.xdrv;
	assign pll_enable        = (q.src == SRC_PLL);
	assign pll_locked        = q.locked;
	assign machine_clock     = q.mclk;

endmodule : mcg_clock_gen

// ==== sim/mcg_clock_gen_sva.sv ====
// Port checker of the machine clock generator
`timescale 1ns/10ps
module mcg_clock_gen_sva #(
	parameter int LOCK_CYCLES = 20
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic reference_clock_input,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic osc_enable,
	input wire logic crystal_drive_pin,
	input wire logic pll_enable,
	input wire logic pll_locked,
	input wire logic machine_clock
);
	localparam int LK = LOCK_CYCLES + 4;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	// ==========
	// Clock source
	a_xtal_off: assert property (!osc_enable |=> !crystal_drive_pin)
		else $error("crystal driven with oscillator off");
	a_xtal_follow: assert property (
		osc_enable |=> crystal_drive_pin == !$past(reference_clock_input))
		else $error("crystal drive does not follow reference");
	a_bypass_lock: assert property (!pll_enable |-> pll_locked)
		else $error("bypass mode not reported locked");
	a_lock_hold: assert property ($fell(pll_locked) |-> !pll_locked[*8])
		else $error("lock came back too soon");
	a_lock_bound: assert property ($fell(pll_locked) |-> ##[1:LK] pll_locked)
		else $error("lock not reached in time");
	// Fixed window covers detector and toggle stages
	a_ref_static: assert property (
		$stable(reference_clock_input)[*4] ##0 !pll_enable |=> $stable(machine_clock))
		else $error("machine clock moved with reference stopped");
	// ==========
	// Register bus
	a_b_stand: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_r_stand: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read data dropped");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
endmodule : mcg_clock_gen_sva

// ==== sim/mcg_ref_src.sv ====
// Reference clock source standing in for crystal or external oscillator
`timescale 1ns/10ps
module mcg_ref_src (
	input wire logic        ref_clk,
	input wire logic        run,
	input wire logic [15:0] half,
	output logic            level = 1'b0
);
	int cnt = 0;
	// ==========
	// A stopped source holds its level, like a gated oscillator
	always @(posedge ref_clk) begin
		if (run) begin
			cnt <= (cnt + 1 >= half) ? 0 : cnt + 1;
			if (cnt + 1 >= half) level <= ~level;
		end
	end
endmodule : mcg_ref_src

// ==== sim/testbench.sv ====
// Self-checking bench of the machine clock generator
`timescale 1ns/10ps
module testbench;
	import mcg_pkg::*;
	typedef struct {
		logic [2:0] p;
		logic       osc;
		logic       pll;
		int         mt;
	} mcg_row_t;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic        reference_clock_input;
	logic [2:0]  pins = 3'h0;
	logic        run = 1'b1;
	logic [3:0]  s_axi_awaddr = 4'h0;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready = 1'b0;
	logic [3:0]  s_axi_araddr = 4'h0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready = 1'b0;
	logic        osc_enable, crystal_drive_pin, pll_enable, pll_locked;
	logic        machine_clock, machine_clock_output;
	int          n_mismatch = 0;
	int          check_count = 0;
	int          k, m, o;
	logic [31:0] d;
	logic [1:0]  r;
	// Toggles in 20 reference periods of 16 cycles
	mcg_row_t    rows [4] = '{
		'{PINS_DIV2_NO_OSC, 1'b0, 1'b0, 20},
		'{PINS_DIV4, 1'b1, 1'b0, 10},
		'{PINS_DIV2, 1'b1, 1'b0, 20},
		'{3'h2, 1'b1, 1'b1, 40}
	};

	always #2.5 ref_clk = ~ref_clk;

	mcg_ref_src src_u (.ref_clk, .run, .half(16'd8), .level(reference_clock_input));

	mcg_clock_gen #(.LOCK_CYCLES(16'd20)) dut_u (
		.ref_clk, .reset, .reference_clock_input,
		.mode_select_pin_1(pins[2]), .mode_select_pin_2(pins[1]),
		.mode_select_pin_3(pins[0]),
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .osc_enable, .crystal_drive_pin, .pll_enable,
		.pll_locked, .machine_clock, .machine_clock_output
	);

	// ==========
	// Helpers
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude

	task automatic hang;
		n_mismatch++;
		$display("BAD t=%0t timeout got %h exp %h", $time, 1'b0, 1'b1);
		conclude();
	endtask : hang

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input int tol = 0);
		check_count++;
		if (tol == 0 ? g !== e : (g > e + tol || g + tol < e)) begin
			n_mismatch++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc

	task automatic rst(input logic [2:0] p);
		pins <= p;
		reset <= 1'b1;
		cyc(2);
		reset <= 1'b0;
		cyc(1);
	endtask : rst

	// Ready is raised late on purpose so a pending answer must stand
	task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
		int i;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) break;
			if (s_axi_bvalid) s_axi_bready <= 1'b1;
		end
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (i == 50) hang();
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
		int i;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) break;
			if (s_axi_rvalid) s_axi_rready <= 1'b1;
		end
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (i == 50) hang();
	endtask : rd

	task automatic meas(output int mc, output int oc);
		logic pm, po;
		mc = 0;
		oc = 0;
		pm = machine_clock;
		po = machine_clock_output;
		repeat (320) begin
			@(posedge ref_clk);
			if (machine_clock !== pm) mc++;
			if (machine_clock_output !== po) oc++;
			pm = machine_clock;
			po = machine_clock_output;
		end
	endtask : meas

	// ==========
	// Sequence
	initial begin
		for (k = 0; k < 4; k++) begin
			rst(rows[k].p);
			cyc(200);
			chk(osc_enable, rows[k].osc);
			chk(pll_enable, rows[k].pll);
			chk(pll_locked, 1'b1);
			rd(OFS_STAT, d, r);
			chk(d[6:4], rows[k].p);
			rd(OFS_BANK, d, r);
			chk(d[1:0], DIV_RESET);
			meas(m, o);
			chk(m, rows[k].mt, 2);
			chk(o, rows[k].mt / 4, 1);
			$display("row %0d done", k);
		end
		for (k = 0; k < 4; k++) begin
			wr(OFS_MODE, 32'h108 | k, r);
			chk(r, RESP_OKAY);
			cyc(1);
			chk(pll_locked, 1'b0);
			for (m = 0; m < 30 && pll_locked !== 1'b1; m++) cyc(1);
			if (m == 30) hang();
			cyc(100);
			meas(m, o);
			chk(m, 80 + 10 * k, 2);
		end
		for (k = 0; k < 4; k++) begin
			wr(OFS_BANK, k, r);
			cyc(20);
			meas(m, o);
			chk(o, m >> (k == 0 ? 0 : k == 1 ? 1 : 2), 1);
		end
		wr(OFS_MODE, 32'h200, r);
		cyc(20);
		chk(pll_enable, 1'b0);
		chk(pll_locked, 1'b1);
		meas(m, o);
		chk(m, 10, 2);
		wr(OFS_MODE, 32'h4, r);
		cyc(20);
		meas(m, o);
		chk(m, 20, 2);
		wr(OFS_MODE, 32'h100, r);
		cyc(30);
		chk(pll_locked, 1'b1);
		meas(m, o);
		chk(m, 40, 2);
		rd(4'hc, d, r);
		chk(r, RESP_SLVERR);
		chk(d, 32'h0);
		wr(4'hc, 32'h0, r);
		chk(r, RESP_SLVERR);
		$display("register tests done");
		rst(PINS_DIV4);
		pins <= PINS_DIV2_NO_OSC;
		cyc(50);
		rd(OFS_STAT, d, r);
		chk(d[6:4], PINS_DIV4);
		chk(osc_enable, 1'b1);
		meas(m, o);
		chk(m, 10, 2);
		run <= 1'b0;
		cyc(10);
		meas(m, o);
		chk(m, 0);
		run <= 1'b1;
		cyc(10);
		meas(m, o);
		chk(m, 10, 2);
		$display("hand tests done");
		conclude();
	end
endmodule : testbench

bind mcg_clock_gen mcg_clock_gen_sva #(.LOCK_CYCLES(LOCK_CYCLES)) sva_u (
	.ref_clk, .reset, .reference_clock_input, .s_axi_awready, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.osc_enable, .crystal_drive_pin, .pll_enable, .pll_locked, .machine_clock
);
